// ### core/ccm_top.sv
// Two-channel mode control, decode, timer and APB register file
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ccm_top
  import ccm_pkg::*;
(
  input wire logic pclk, // Core clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic cap_pin1, // Channel 1 input pin
  input wire logic cap_pin2, // Channel 2 input pin
  input wire logic adc_enabled, // Analog converter is enabled
  output logic cmp_out1, // Channel 1 compare output latch
  output logic cmp_out2, // Channel 2 compare output latch
  output logic [9:0] pwm_duty1, // Channel 1 10-bit duty value
  output logic [9:0] pwm_duty2, // Channel 2 10-bit duty value
  output logic pwm_on1, // Channel 1 in PWM mode
  output logic pwm_on2, // Channel 2 in PWM mode
  output logic timer_reset, // Special trigger reset pulse
  output logic adc_start, // Conversion start pulse
  output logic irq // Level interrupt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] ctl1; // channel1_mode_control
    logic [5:0] ctl2; // channel2_mode_control
    logic [7:0] duty1; // duty_high_byte_reg, channel 1
    logic [7:0] duty2; // duty_high_byte_reg, channel 2
    logic [15:0] cmp1; // Channel 1 compare value
    logic [15:0] cmp2; // Channel 2 compare value
    logic [15:0] timer; // timer_one_counter
    logic run; // Timer run bit
    logic [2:0] ists; // Sticky status
    logic [2:0] ien; // Interrupt enable
    logic [1:0] sync1; // Pin synchroniser first stage
    logic [1:0] sync2; // Pin synchroniser second stage
    logic [31:0] prdata; // Read data
    logic pready; // Ready
    logic pslverr; // Error
    logic [9:0] pwm1; // Channel 1 duty out
    logic [9:0] pwm2; // Channel 2 duty out
    logic pwm_on1; // Channel 1 PWM flag
    logic pwm_on2; // Channel 2 PWM flag
    logic out1; // Channel 1 pin copy
    logic out2; // Channel 2 pin copy
    logic tmr_rst; // Timer reset pulse
    logic adc_go; // Conversion start pulse
    logic irq; // Interrupt level
  } ccm_top_state_t;

  ccm_top_state_t s; // Current state
  ccm_top_state_t next_s; // Next state
  ccm_chan_in_t cin1; // Channel 1 inputs
  ccm_chan_in_t cin2; // Channel 2 inputs
  ccm_chan_out_t cout1; // Channel 1 outputs
  ccm_chan_out_t cout2; // Channel 2 outputs

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Each channel sees its stored mode, synced pin and the timer
  assign cin1 = '{mode: s.ctl1[3:0], pin: s.sync2[0], timer: s.timer, compare: s.cmp1};
  assign cin2 = '{mode: s.ctl2[3:0], pin: s.sync2[1], timer: s.timer, compare: s.cmp2};

  ccm_chan u_ch1 (
    .pclk(pclk),
    .presetn(presetn),
    .cin(cin1),
    .cout(cout1)
  );

  ccm_chan u_ch2 (
    .pclk(pclk),
    .presetn(presetn),
    .cin(cin2),
    .cout(cout2)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] idx;
    logic mapped;
    logic wr;
    logic [31:0] rd;
    logic [2:0] set_bits;
    logic [2:0] clr_bits;
    logic any_trig;
    idx = paddr[9:2];
    mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    rd = 32'h0000_0000;
    next_s = s;
    // Pins pass two flops before use
    next_s.sync1 = {cap_pin2, cap_pin1};
    next_s.sync2 = s.sync1;
    // Read mux and decode
    if (mapped) begin
      unique case (idx)
        CCM_IDX_CH1_CTL: rd = {26'h0, s.ctl1};
        CCM_IDX_CH2_CTL: rd = {26'h0, s.ctl2};
        CCM_IDX_DUTY1: rd = {24'h0, s.duty1};
        CCM_IDX_DUTY2: rd = {24'h0, s.duty2};
        CCM_IDX_CMP1: rd = {16'h0, s.cmp1};
        CCM_IDX_CMP2: rd = {16'h0, s.cmp2};
        CCM_IDX_CAP1: rd = {16'h0, cout1.capture};
        CCM_IDX_CAP2: rd = {16'h0, cout2.capture};
        CCM_IDX_TIMER: rd = {16'h0, s.timer};
        CCM_IDX_TCTL: rd = {31'h0, s.run};
        CCM_IDX_ISTS: rd = {29'h0, s.ists};
        CCM_IDX_IEN: rd = {29'h0, s.ien};
        CCM_IDX_ICLR: rd = 32'h0000_0000;
        default: mapped = 1'b0;
      endcase
    end
    // Setup cycle prepares the answer for the access cycle
    next_s.pready = psel & ~penable;
    next_s.pslverr = psel & ~penable & ~mapped;
    next_s.prdata = (psel & ~penable & ~pwrite) ? rd : 32'h0000_0000;
    wr = psel & penable & s.pready & pwrite & mapped;
    clr_bits = 3'h0;
    // Register writes
    if (wr) begin
      unique case (idx)
        CCM_IDX_CH1_CTL: next_s.ctl1 = pwdata[CCM_CTL_W-1:0];
        CCM_IDX_CH2_CTL: next_s.ctl2 = pwdata[CCM_CTL_W-1:0];
        CCM_IDX_DUTY1: next_s.duty1 = pwdata[7:0];
        CCM_IDX_DUTY2: next_s.duty2 = pwdata[7:0];
        CCM_IDX_CMP1: next_s.cmp1 = pwdata[15:0];
        CCM_IDX_CMP2: next_s.cmp2 = pwdata[15:0];
        CCM_IDX_TCTL: next_s.run = pwdata[0];
        CCM_IDX_IEN: next_s.ien = pwdata[CCM_ST_W-1:0];
        CCM_IDX_ICLR: clr_bits = pwdata[CCM_ST_W-1:0];
        default: begin
        end
      endcase
    end
    // Timer one counter
    any_trig = cout1.trig | cout2.trig;
    set_bits = 3'h0;
    set_bits[CCM_ST_CH1] = cout1.cap_evt | cout1.match_evt;
    set_bits[CCM_ST_CH2] = cout2.cap_evt | cout2.match_evt;
    if (any_trig) begin
      // trigger clears timer, no overflow flag
      next_s.timer = CCM_WORD_RST;
    end else if (s.run) begin
      next_s.timer = s.timer + 16'h0001;
      set_bits[CCM_ST_TOVF] = (s.timer == CCM_TIMER_MAX);
    end
    // trigger resets timer and may start a conversion
    next_s.tmr_rst = any_trig;
    next_s.adc_go = cout2.trig & adc_enabled;
    // Status: a set in the clearing cycle wins
    next_s.ists = (s.ists & ~clr_bits) | set_bits;
    next_s.irq = |(next_s.ists & next_s.ien);
    // duty low bits are the control register's 5-4
    // duty value only presented in PWM mode
    next_s.pwm_on1 = (next_s.ctl1[3:2] == CCM_M_PWM_TOP);
    next_s.pwm_on2 = (next_s.ctl2[3:2] == CCM_M_PWM_TOP);
    next_s.pwm1 = next_s.pwm_on1 ? {next_s.duty1, next_s.ctl1[5:CCM_DUTY_LSB_POS]} : 10'h000;
    next_s.pwm2 = next_s.pwm_on2 ? {next_s.duty2, next_s.ctl2[5:CCM_DUTY_LSB_POS]} : 10'h000;
    next_s.out1 = cout1.out_pin;
    next_s.out2 = cout2.out_pin;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // every implemented bit clears at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign cmp_out1 = s.out1;
  assign cmp_out2 = s.out2;
  assign pwm_duty1 = s.pwm1;
  assign pwm_duty2 = s.pwm2;
  assign pwm_on1 = s.pwm_on1;
  assign pwm_on2 = s.pwm_on2;
  assign timer_reset = s.tmr_rst;
  assign adc_start = s.adc_go;
  assign irq = s.irq;

endmodule : ccm_top
`default_nettype wire

// ### core/ccm_pkg.sv
// Shared constants and carrier types of the two-channel mode control block
package ccm_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] CCM_IDX_CH1_CTL = 8'h17; // channel1_mode_control
  localparam logic [7:0] CCM_IDX_CH2_CTL = 8'h1D; // channel2_mode_control
  localparam logic [7:0] CCM_IDX_DUTY1 = 8'h00; // Channel 1 duty high byte
  localparam logic [7:0] CCM_IDX_DUTY2 = 8'h01; // Channel 2 duty high byte
  localparam logic [7:0] CCM_IDX_CMP1 = 8'h02; // Channel 1 compare value
  localparam logic [7:0] CCM_IDX_CMP2 = 8'h03; // Channel 2 compare value
  localparam logic [7:0] CCM_IDX_CAP1 = 8'h04; // Channel 1 capture value
  localparam logic [7:0] CCM_IDX_CAP2 = 8'h05; // Channel 2 capture value
  localparam logic [7:0] CCM_IDX_TIMER = 8'h06; // Timer one counter
  localparam logic [7:0] CCM_IDX_TCTL = 8'h07; // Timer run control
  localparam logic [7:0] CCM_IDX_ISTS = 8'h08; // Sticky event status
  localparam logic [7:0] CCM_IDX_IEN = 8'h09; // Interrupt enable
  localparam logic [7:0] CCM_IDX_ICLR = 8'h0A; // Write-one-to-clear

  // ----------------------------------------------------------------
  // Field layout of a mode control register and of the status bits
  // ----------------------------------------------------------------
  localparam int CCM_CTL_W = 6; // Implemented low bits
  localparam int CCM_DUTY_LSB_POS = 4; // duty_low_bit0 position
  localparam int CCM_MODE_W = 4; // mode_select_bit3..0
  localparam int CCM_ST_CH1 = 0; // Status: channel 1 event flag
  localparam int CCM_ST_CH2 = 1; // Status: channel 2 event flag
  localparam int CCM_ST_TOVF = 2; // Status: timer overflow flag
  localparam int CCM_ST_W = 3; // Status width

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] CCM_CTL_RST = 6'h00; // Mode control at power-on
  localparam logic [7:0] CCM_DUTY_RST = 8'h00; // Duty byte
  localparam logic [15:0] CCM_WORD_RST = 16'h0000; // Compare, capture, timer
  localparam logic [2:0] CCM_ST_RST = 3'h0; // Status and enable

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] CCM_M_OFF = 4'h0; // Channel off
  localparam logic [3:0] CCM_M_CAP_FALL = 4'h4; // Capture every falling edge
  localparam logic [3:0] CCM_M_CAP_RISE = 4'h5; // Capture every rising edge
  localparam logic [3:0] CCM_M_CAP_R4 = 4'h6; // Capture every 4th rise
  localparam logic [3:0] CCM_M_CAP_R16 = 4'h7; // Capture every 16th rise
  localparam logic [3:0] CCM_M_CMP_HI = 4'h8; // Compare, drive high
  localparam logic [3:0] CCM_M_CMP_LO = 4'h9; // Compare, drive low
  localparam logic [3:0] CCM_M_CMP_SW = 4'hA; // Compare, flag only
  localparam logic [3:0] CCM_M_CMP_TRIG = 4'hB; // Compare, special trigger
  localparam logic [1:0] CCM_M_PWM_TOP = 2'h3; // 11xx is PWM
  localparam logic [3:0] CCM_PRE4_LAST = 4'h3; // Last count of 1:4
  localparam logic [3:0] CCM_PRE16_LAST = 4'hF; // Last count of 1:16
  localparam logic [15:0] CCM_TIMER_MAX = 16'hFFFF; // Timer wrap point

  // ----------------------------------------------------------------
  // Carriers between top and channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] mode; // Mode selector
    logic pin; // Synchronised channel input pin
    logic [15:0] timer; // Timer one counter value
    logic [15:0] compare; // Compare value
  } ccm_chan_in_t;

  typedef struct packed {
    logic cap_evt; // Capture taken this cycle
    logic match_evt; // Compare match event this cycle
    logic trig; // Special event trigger pulse
    logic out_pin; // Compare output latch
    logic [15:0] capture; // Captured timer value
  } ccm_chan_out_t;

endpackage : ccm_pkg

// ### core/ccm_chan.sv
// One capture/compare channel: mode decode, prescaler, capture and compare
`timescale 1ns/10ps
`default_nettype none
module ccm_chan
  import ccm_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire ccm_chan_in_t cin, // Mode, pin, timer, compare
  output ccm_chan_out_t cout // Events, latch, capture
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_prev; // Pin one cycle ago
    logic eq_prev; // Timer matched last cycle
    logic [3:0] presc; // Rising edge prescale count
    ccm_chan_out_t o; // Registered outputs
  } ccm_chan_state_t;

  ccm_chan_state_t s; // Current state
  ccm_chan_state_t next_s; // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic eq_now;
    logic hit;
    rise = cin.pin & ~s.pin_prev;
    fall = ~cin.pin & s.pin_prev;
    eq_now = (cin.timer == cin.compare);
    hit = eq_now & ~s.eq_prev;
    next_s = s;
    next_s.pin_prev = cin.pin;
    next_s.eq_prev = eq_now;
    next_s.o.cap_evt = 1'b0;
    next_s.o.match_evt = 1'b0;
    next_s.o.trig = 1'b0;
    // Prescaler only counts in capture modes
    if (cin.mode[3:2] != 2'b01) begin
      next_s.presc = 4'h0;
    end
    case (cin.mode)
      CCM_M_OFF: begin
        next_s.o.out_pin = 1'b0;
      end
      CCM_M_CAP_FALL: begin
        next_s.o.cap_evt = fall;
      end
      CCM_M_CAP_RISE: begin
        next_s.o.cap_evt = rise;
      end
      CCM_M_CAP_R4, CCM_M_CAP_R16: begin
        if (rise) begin
          if (s.presc == ((cin.mode == CCM_M_CAP_R4) ? CCM_PRE4_LAST : CCM_PRE16_LAST)) begin
            next_s.presc = 4'h0;
            next_s.o.cap_evt = 1'b1;
          end else begin
            next_s.presc = s.presc + 4'h1;
          end
        end
      end
      // compare drives pin high or low
      CCM_M_CMP_HI, CCM_M_CMP_LO: begin
        next_s.o.match_evt = hit;
        if (hit) begin
          next_s.o.out_pin = (cin.mode == CCM_M_CMP_HI);
        end
      end
      CCM_M_CMP_SW: begin
        next_s.o.match_evt = hit;
      end
      CCM_M_CMP_TRIG: begin
        next_s.o.match_evt = hit;
        next_s.o.trig = hit;
      end
      // reserved and PWM codes act not here
      default: begin
      end
    endcase
    if (next_s.o.cap_evt) begin
      next_s.o.capture = cin.timer;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cout = s.o;

endmodule : ccm_chan
`default_nettype wire

// ### bench/ccm_pin_model.sv
// Far-side source that drives the two channel input pins
`timescale 1ns/10ps
`default_nettype none
module ccm_pin_model (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Reset, active low
  input wire logic [1:0] lvl_req, // Levels asked by the bench
  output logic [1:0] pins // Driven input pins
);
  // Pins follow a request one edge later, like a real source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 2'h0;
    end else begin
      pins <= lvl_req;
    end
  end
endmodule : ccm_pin_model
`default_nettype wire

// ### bench/ccm_sva.sv
// Port-level assertions of the mode control block
`timescale 1ns/10ps
`default_nettype none
module ccm_sva
  import ccm_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic cmp_out1, // Compare latch 1
  input wire logic [9:0] pwm_duty1, // Duty value 1
  input wire logic pwm_on1, // PWM 1 on
  input wire logic timer_reset, // Trigger pulse
  input wire logic adc_start // Conversion start
);
  localparam logic [11:0] A_C1 = {2'b00, CCM_IDX_CH1_CTL, 2'b00}; // Ctl 1
  localparam logic [11:0] A_C2 = {2'b00, CCM_IDX_CH2_CTL, 2'b00}; // Ctl 2
  localparam logic [11:0] A_D1 = {2'b00, CCM_IDX_DUTY1, 2'b00}; // Duty 1
  logic wr; // Write completes at this edge
  logic [5:0] m1; // Shadow of ctl 1
  logic [5:0] m2; // Shadow of ctl 2
  logic [7:0] d1; // Shadow of duty 1
  assign wr = psel && penable && pready && pwrite;
  // Shadows follow completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m1 <= 6'h00;
      m2 <= 6'h00;
      d1 <= 8'h00;
    end else begin
      m1 <= (wr && paddr == A_C1) ? pwdata[5:0] : m1;
      m2 <= (wr && paddr == A_C2) ? pwdata[5:0] : m2;
      d1 <= (wr && paddr == A_D1) ? pwdata[7:0] : d1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_apb_answer;
    s_setup |=> s_access;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no answer after setup");
  property p_ctl_top;
    pready && !pwrite && (paddr == A_C1 || paddr == A_C2) |-> prdata[31:6] == 26'h0;
  endproperty
  a_ctl_top: assert property (p_ctl_top) else $error("ctl top bits set");
  property p_pwm_on;
    pwm_on1 == (m1[3:2] == CCM_M_PWM_TOP);
  endproperty
  a_pwm_on: assert property (p_pwm_on) else $error("pwm on wrong");
  property p_pwm_duty;
    pwm_duty1 == ((m1[3:2] == CCM_M_PWM_TOP) ? {d1, m1[5:4]} : 10'h000);
  endproperty
  a_pwm_duty: assert property (p_pwm_duty) else $error("duty value wrong");
  property p_pin_rise;
    $rose(cmp_out1) |-> m1[3:0] == CCM_M_CMP_HI;
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("latch rose");
  property p_pin_fall;
    $fell(cmp_out1) |-> m1[3:0] == CCM_M_CMP_LO || m1[3:0] == CCM_M_OFF;
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("latch fell");
  property p_sw_hold;
    m1[3:0] == CCM_M_CMP_SW ##1 m1[3:0] == CCM_M_CMP_SW |-> $stable(cmp_out1);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("latch moved");
  property p_trig_mode;
    timer_reset |-> m1[3:0] == CCM_M_CMP_TRIG || m2[3:0] == CCM_M_CMP_TRIG;
  endproperty
  a_trig_mode: assert property (p_trig_mode) else $error("stray timer reset");
  property p_adc;
    adc_start |-> timer_reset && m2[3:0] == CCM_M_CMP_TRIG;
  endproperty
  a_adc: assert property (p_adc) else $error("stray conversion");
endmodule : ccm_sva
bind ccm_top ccm_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .cmp_out1(cmp_out1), .pwm_duty1(pwm_duty1), .pwm_on1(pwm_on1),
  .timer_reset(timer_reset), .adc_start(adc_start));
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench of the two-channel mode control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  import ccm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // Clock, reset, APB
  logic [11:0] paddr; // APB address
  logic [31:0] pwdata, prdata, rdat; // Write, read, last read data
  logic [1:0] pin_req, pins; // Pin requests and pins
  logic adc_enabled, cmp_out1, cmp_out2, pwm_on1, pwm_on2; // Side signals
  logic timer_reset, adc_start, irq, rerr; // Events, last error
  logic [9:0] pwm_duty1, pwm_duty2; // Duty values
  logic [15:0] tval; // Frozen timer value
  int err_total, num_checks; // Counters
  logic [3:0] cap_mode [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h5}; // Capture modes
  int cap_cnt [5] = '{1, 1, 4, 16, 1}; // Rises per capture
  int cap_ch [5] = '{0, 0, 0, 0, 1}; // Channel of each row
  logic [7:0] ctl_idx [2] = '{CCM_IDX_CH1_CTL, CCM_IDX_CH2_CTL}; // Ctl indices
  logic [7:0] cap_idx [2] = '{CCM_IDX_CAP1, CCM_IDX_CAP2}; // Capture indices
  ccm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cap_pin1(pins[0]), .cap_pin2(pins[1]), .adc_enabled(adc_enabled), .cmp_out1(cmp_out1),
    .cmp_out2(cmp_out2), .pwm_duty1(pwm_duty1), .pwm_duty2(pwm_duty2), .pwm_on1(pwm_on1),
    .pwm_on2(pwm_on2), .timer_reset(timer_reset), .adc_start(adc_start), .irq(irq));
  ccm_pin_model pin_src (.pclk(pclk), .presetn(presetn), .lvl_req(pin_req), .pins(pins));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One APB transfer, pready waited for under a bound
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask : rd
  // Pin level change, then time to cross the synchroniser
  task automatic pulse(input int c, input logic v);
    @(posedge pclk);
    pin_req[c] <= v;
    repeat (10) @(posedge pclk);
  endtask : pulse
  // Wait for k trigger pulses, each under a bound
  task automatic wait_trig(input int k);
    int n;
    for (int i = 0; i < k; i++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (timer_reset !== 1'b1 && n < 400);
      if (n >= 400) err_total++;
    end
  endtask : wait_trig
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pin_req, adc_enabled} = '0;
    err_total = 0;
    num_checks = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      rd(ctl_idx[i]);
      `CHK("ctl reset", rdat, 32'h0)
      wr(ctl_idx[i], 32'hFF);
      rd(ctl_idx[i]);
      `CHK("ctl readback", rdat, 32'h3F)
    end
    rd(8'hFF);
    `CHK("unmapped", {rerr, rdat}, 33'h100000000)
    wr(CCM_IDX_DUTY1, 32'hA5);
    wr(CCM_IDX_DUTY2, 32'h3C);
    wr(CCM_IDX_CH1_CTL, 32'h2C);
    wr(CCM_IDX_CH2_CTL, 32'h1F);
    repeat (3) @(posedge pclk);
    `CHK("pwm on", {pwm_on1, pwm_on2}, 2'b11)
    `CHK("duty 1", pwm_duty1, {8'hA5, 2'b10})
    `CHK("duty 2", pwm_duty2, {8'h3C, 2'b01})
    wr(CCM_IDX_CH1_CTL, 32'h35);
    repeat (3) @(posedge pclk);
    `CHK("duty unused", {pwm_on1, pwm_duty1}, 11'h000)
    rd(CCM_IDX_CH1_CTL);
    `CHK("duty kept", rdat, 32'h35)
    wr(CCM_IDX_TCTL, 32'h1);
    repeat (20) @(posedge pclk);
    wr(CCM_IDX_TCTL, 32'h0);
    rd(CCM_IDX_TIMER);
    tval = rdat[15:0];
    `CHK("timer ran", tval != 16'h0, 1'b1)
    for (int k = 0; k < 5; k++) begin
      wr(ctl_idx[cap_ch[k]], 32'h0);
      wr(CCM_IDX_ICLR, 32'h7);
      wr(ctl_idx[cap_ch[k]], {28'h0, cap_mode[k]});
      for (int i = 0; i < cap_cnt[k]; i++) begin
        pulse(cap_ch[k], 1'b1);
        rd(CCM_IDX_ISTS);
        `CHK("rise", rdat[cap_ch[k]], cap_mode[k] != 4'h4 && i == cap_cnt[k] - 1)
        pulse(cap_ch[k], 1'b0);
        rd(CCM_IDX_ISTS);
        `CHK("fall", rdat[cap_ch[k]], i == cap_cnt[k] - 1)
      end
      rd(cap_idx[cap_ch[k]]);
      `CHK("capture", rdat, {16'h0, tval})
    end
    wr(CCM_IDX_CMP2, 32'h80);
    wr(CCM_IDX_CMP1, 32'h40);
    wr(CCM_IDX_CH2_CTL, 32'h0B);
    wr(CCM_IDX_CH1_CTL, 32'h08);
    wr(CCM_IDX_ICLR, 32'h7);
    wr(CCM_IDX_IEN, 32'h2);
    adc_enabled <= 1'b1;
    wr(CCM_IDX_TCTL, 32'h1);
    wait_trig(1);
    `CHK("trigger", {adc_start, irq}, 2'b11)
    wr(CCM_IDX_ICLR, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq clear", irq, 1'b0)
    wait_trig(1);
    wr(CCM_IDX_IEN, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK("irq mask", irq, 1'b0)
    rd(CCM_IDX_ISTS);
    `CHK("status", rdat, 32'h3)
    `CHK("latches", {cmp_out1, cmp_out2}, 2'b10)
    wr(CCM_IDX_CH1_CTL, 32'h09);
    wait_trig(2);
    `CHK("pin low", cmp_out1, 1'b0)
    wr(CCM_IDX_CH1_CTL, 32'h08);
    wait_trig(2);
    wr(CCM_IDX_CH1_CTL, 32'h0A);
    wr(CCM_IDX_ICLR, 32'h1);
    wait_trig(2);
    rd(CCM_IDX_ISTS);
    `CHK("flag only", {cmp_out1, rdat[0]}, 2'b11)
    wr(CCM_IDX_CH1_CTL, 32'h02);
    wr(CCM_IDX_ICLR, 32'h1);
    wait_trig(2);
    rd(CCM_IDX_ISTS);
    `CHK("reserved", rdat[0], 1'b0)
    wr(CCM_IDX_CH1_CTL, 32'h00);
    repeat (3) @(posedge pclk);
    `CHK("off latch", cmp_out1, 1'b0)
    adc_enabled <= 1'b0;
    wait_trig(1);
    `CHK("adc gated", adc_start, 1'b0)
    rd(CCM_IDX_ISTS);
    `CHK("no overflow", rdat[2], 1'b0)
    end_sim();
  end
endmodule : testbench
`default_nettype wire
